// ---- include/sstk_params.svh ----
`ifndef SSTK_PARAMS_SVH
`define SSTK_PARAMS_SVH
`define SSTK_RESET_PTR 16'h1000
`define SSTK_WORD_STEP 16'h0002
`define SSTK_ALIGN_BIT 0
`define SSTK_PC_LO_MSB 15
`define SSTK_PC_HI_MSB 22
`define SSTK_PC_HI_LSB 16
`define SSTK_STATUS_LO_MSB 7
`define SSTK_STATUS_POS_MSB 15
`define SSTK_STATUS_POS_LSB 8
`endif

// ---- include/sstk_pkg.sv ----
package sstk_pkg;
	typedef enum logic [2:0] {
		SSTK_IDLE = 3'b000,
		SSTK_PUSH_LO = 3'b001,
		SSTK_PUSH_HI = 3'b010,
		SSTK_POP = 3'b011,
		SSTK_POP_RD = 3'b100
	} sstk_state_type;
	typedef enum logic [1:0] {
		SSTK_OP_NONE = 2'b00,
		SSTK_OP_PUSH = 2'b01,
		SSTK_OP_POP = 2'b10,
		SSTK_OP_SAVE_PC = 2'b11
	} sstk_op_type;
endpackage

// ---- include/sstk_ptr_if.sv ----
`timescale 1ns/10ps
interface sstk_ptr_if;
	logic wr_en;
	logic [15:0] wr_data;
	logic inc;
	logic dec;
	logic [15:0] ptr;
	modport owner(input wr_en, wr_data, inc, dec, output ptr);
	modport user(output wr_en, wr_data, inc, dec, input ptr);
endinterface

// ---- verilog/sstk_ptr_reg.sv ----
`timescale 1ns/10ps
`include "sstk_params.svh"
module sstk_ptr_reg
	import sstk_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	sstk_ptr_if.owner p
);
	logic [15:0] ptr_q;
	logic [15:0] ptr_d;
	always_comb begin
		ptr_d = ptr_q;
		if (p.wr_en) begin
			ptr_d = p.wr_data; // RULE12
		end else if (p.inc) begin
			ptr_d = ptr_q + `SSTK_WORD_STEP; // RULE6
		end else if (p.dec) begin
			ptr_d = ptr_q - `SSTK_WORD_STEP; // RULE6
		end
		ptr_d[`SSTK_ALIGN_BIT] = 1'b0; // RULE3
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ptr_q <= `SSTK_RESET_PTR; // RULE4
		end else begin
			ptr_q <= ptr_d;
		end
	end
	assign p.ptr = ptr_q;
endmodule

// ---- verilog/sstk_top.sv ----
`timescale 1ns/10ps
`include "sstk_params.svh"
// Behaviour
// (RULE1) pointer register updates itself on exceptions, calls and returns
// (RULE2) software reads and writes pointer like any working register
// (RULE3) pointer bit zero always held at zero
// (RULE4) any reset loads pointer with 0x1000
// (RULE5) pointer addresses next free word; stack grows upward
// (RULE6) push writes then increments; pop decrements then reads
// (RULE7) pc low sixteen bits pushed first, upper bits next word
// (RULE8) call zero-fills upper bits of second pc word
// (RULE9) exception puts status low byte into upper second pc word
// (RULE10) stack addresses never paged, confined to 0x0000..0xFFFF
// (RULE11) frame pointer unpaged too when frame flag is one
// (RULE12) software may relocate pointer; later pushes use new value
// (RULE13) written bit zero ignored; reads return zero there
module sstk_top
	import sstk_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic op_valid,
	input wire sstk_op_type op_code,
	input wire logic op_is_exception,
	input wire logic [15:0] push_data,
	input wire logic [22:0] pc_value,
	input wire logic [15:0] cpu_status_register,
	input wire logic sw_wr_en,
	input wire logic [15:0] sw_wr_data,
	input wire logic frame_pointer_active_flag,
	input wire logic [15:0] frame_pointer_register,
	input wire logic [15:0] mem_rd_data,
	output logic op_busy,
	output logic op_done,
	output logic [15:0] pop_data,
	output logic [15:0] stack_pointer_register,
	output logic mem_wr_en,
	output logic mem_rd_en,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wr_data,
	output logic frame_unpaged,
	output logic [15:0] frame_addr
);
	// ****************************************
	// pointer register
	// ****************************************
	sstk_ptr_if ptr_bus();
	sstk_ptr_reg u_ptr (
		.clk(clk),
		.reset_n(reset_n),
		.p(ptr_bus)
	);
	// ****************************************
	// sequencer
	// ****************************************
	sstk_state_type state_q, state_d;
	logic [15:0] hi_word_q, hi_word_d;
	logic busy_d, done_d, wr_d, rd_d;
	logic [15:0] addr_d, wdata_d, pop_d;
	logic [15:0] hi_word_calc;
	// ****************************************
	// saved pc high word
	// ****************************************
	// upper word: pc high bits, status low byte on exceptions
	always_comb begin
		hi_word_calc = '0; // RULE8
		hi_word_calc[`SSTK_PC_HI_MSB-`SSTK_PC_HI_LSB:0] =
			pc_value[`SSTK_PC_HI_MSB:`SSTK_PC_HI_LSB];
		if (op_is_exception) begin
			hi_word_calc[`SSTK_STATUS_POS_MSB:`SSTK_STATUS_POS_LSB] =
				cpu_status_register[`SSTK_STATUS_LO_MSB:0]; // RULE9
		end
	end
	always_comb begin
		state_d = state_q;
		hi_word_d = hi_word_q;
		wr_d = 1'b0;
		rd_d = 1'b0;
		done_d = 1'b0;
		addr_d = stack_pointer_register;
		wdata_d = mem_wr_data;
		pop_d = pop_data;
		ptr_bus.wr_en = 1'b0;
		ptr_bus.wr_data = sw_wr_data; // RULE13
		ptr_bus.inc = 1'b0;
		ptr_bus.dec = 1'b0;
		case (state_q)
			SSTK_IDLE: begin
				if (sw_wr_en) begin
					ptr_bus.wr_en = 1'b1; // RULE2
				end else if (op_valid) begin
					case (op_code) // RULE1
						SSTK_OP_PUSH: begin
							wr_d = 1'b1; // RULE5
							addr_d = ptr_bus.ptr; // RULE10
							wdata_d = push_data;
							ptr_bus.inc = 1'b1; // RULE6
							done_d = 1'b1;
						end
						SSTK_OP_SAVE_PC: begin
							wr_d = 1'b1;
							addr_d = ptr_bus.ptr;
							wdata_d = pc_value[`SSTK_PC_LO_MSB:0]; // RULE7
							hi_word_d = hi_word_calc;
							ptr_bus.inc = 1'b1;
							state_d = SSTK_PUSH_HI;
						end
						SSTK_OP_POP: begin
							ptr_bus.dec = 1'b1; // RULE6
							state_d = SSTK_POP;
						end
						default: begin
						end
					endcase
				end
			end
			SSTK_PUSH_HI: begin
				wr_d = 1'b1; // RULE7
				addr_d = ptr_bus.ptr;
				wdata_d = hi_word_q;
				ptr_bus.inc = 1'b1;
				done_d = 1'b1;
				state_d = SSTK_IDLE;
			end
			SSTK_POP: begin
				rd_d = 1'b1;
				addr_d = ptr_bus.ptr;
				state_d = SSTK_POP_RD;
			end
			SSTK_POP_RD: begin
				// wait one cycle for the ram to return the word
				if (!mem_rd_en) begin
					pop_d = mem_rd_data; // RULE6
					done_d = 1'b1;
					state_d = SSTK_IDLE;
				end
			end
			default: begin
				state_d = SSTK_IDLE;
			end
		endcase
		busy_d = (state_d != SSTK_IDLE);
	end
	// ****************************************
	// sequencer state
	// ****************************************
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_q <= SSTK_IDLE;
			hi_word_q <= '0;
		end else begin
			state_q <= state_d;
			hi_word_q <= hi_word_d;
		end
	end
	// ****************************************
	// handshake outputs
	// ****************************************
	// op_done pulses one cycle; pop_data holds
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			op_busy <= 1'b0;
			op_done <= 1'b0;
			pop_data <= '0;
		end else begin
			op_busy <= busy_d;
			op_done <= done_d;
			pop_data <= pop_d;
		end
	end
	// ****************************************
	// memory port
	// ****************************************
	// addresses stay 16 bits wide, never paged
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			mem_wr_en <= 1'b0;
			mem_rd_en <= 1'b0;
			mem_addr <= '0;
			mem_wr_data <= '0;
		end else begin
			mem_wr_en <= wr_d;
			mem_rd_en <= rd_d;
			mem_addr <= addr_d; // RULE10
			mem_wr_data <= wdata_d;
		end
	end
	// ****************************************
	// pointer mirror
	// ****************************************
	// the mirror trails the internal pointer by one cycle
	logic [15:0] sp_mirror_d;
	always_comb begin
		sp_mirror_d = ptr_bus.ptr;
		sp_mirror_d[`SSTK_ALIGN_BIT] = 1'b0; // RULE13
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stack_pointer_register <= `SSTK_RESET_PTR; // RULE4
		end else begin
			stack_pointer_register <= sp_mirror_d; // RULE2
		end
	end
	// ****************************************
	// frame pointer
	// ****************************************
	// frame pointer is passed on as a plain 16-bit address
	logic frame_unpaged_d;
	logic [15:0] frame_addr_d;
	always_comb begin
		frame_unpaged_d = frame_pointer_active_flag; // RULE11
		frame_addr_d = frame_pointer_register;
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			frame_unpaged <= 1'b0;
			frame_addr <= '0;
		end else begin
			frame_unpaged <= frame_unpaged_d;
			frame_addr <= frame_addr_d;
		end
	end
endmodule

// ---- sim/sstk_ram.sv ----
`timescale 1ns/10ps
module sstk_ram (
	input wire logic clk,
	input wire logic we,
	input wire logic re,
	input wire logic [15:0] addr,
	input wire logic [15:0] wd,
	output logic [15:0] rd
);
	logic [15:0] m [0:32767];
	initial rd = 16'h0000;
	// idle read data toggles so stale words never look valid
	always @(posedge clk) begin
		if (we)
			m[addr[15:1]] <= wd;
		rd <= re ? m[addr[15:1]] : ~rd;
	end
endmodule

// ---- sim/sstk_top_asserts.sv ----
`timescale 1ns/10ps
module sstk_top_asserts
	import sstk_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic op_valid,
	input wire sstk_op_type op_code,
	input wire logic op_busy,
	input wire logic op_done,
	input wire logic sw_wr_en,
	input wire logic [15:0] stack_pointer_register,
	input wire logic mem_wr_en,
	input wire logic mem_rd_en,
	input wire logic [15:0] mem_addr,
	input wire logic frame_pointer_active_flag,
	input wire logic [15:0] frame_pointer_register,
	input wire logic [15:0] frame_addr
);
	wire tk = op_valid && !op_busy && !sw_wr_en;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_al; !stack_pointer_register[0]; endproperty
	a_al: assert property (p_al) else $error("odd pointer");
	property p_rst; $rose(reset_n) |-> stack_pointer_register == 16'h1000; endproperty
	a_rst: assert property (p_rst) else $error("reset pointer");
	property p_psh; tk && op_code == SSTK_OP_PUSH |=> mem_wr_en && op_done; endproperty
	a_psh: assert property (p_psh) else $error("push");
	property p_pop; tk && op_code == SSTK_OP_POP |=> ##1 mem_rd_en ##2 op_done; endproperty
	a_pop: assert property (p_pop) else $error("pop");
	property p_busy; tk && op_code == SSTK_OP_POP |=> op_busy [*3] ##1 !op_busy; endproperty
	a_busy: assert property (p_busy) else $error("pop busy");
	property p_pc; tk && op_code == SSTK_OP_SAVE_PC |=> mem_wr_en
		##1 mem_wr_en && op_done && mem_addr == $past(mem_addr) + 16'h0002; endproperty
	a_pc: assert property (p_pc) else $error("save pc");
	property p_inc; mem_wr_en && op_done |=> stack_pointer_register == $past(mem_addr) + 16'h0002;
	endproperty
	a_inc: assert property (p_inc) else $error("increment");
	property p_fp; frame_pointer_active_flag |=> frame_addr == $past(frame_pointer_register);
	endproperty
	a_fp: assert property (p_fp) else $error("frame");
	property p_nop; tk && op_code == SSTK_OP_NONE |=> !mem_wr_en && !mem_rd_en; endproperty
	a_nop: assert property (p_nop) else $error("no op");
endmodule
bind sstk_top sstk_top_asserts sstk_top_asserts_i (.*);

// ---- sim/tb_sstk_top.sv ----
`timescale 1ns/10ps
module tb_sstk_top;
	import sstk_pkg::*;
	logic clk = 1'b0, reset_n = 1'b0, op_valid = 1'b0, op_is_exception = 1'b0, sw_wr_en = 1'b0;
	logic frame_pointer_active_flag = 1'b0, op_busy, op_done, mem_wr_en, mem_rd_en, frame_unpaged;
	sstk_op_type op_code = SSTK_OP_NONE;
	logic [22:0] pc_value = 23'h000000;
	logic [15:0] push_data = 16'h0000, cpu_status_register = 16'h0000, sw_wr_data = 16'h0000;
	logic [15:0] frame_pointer_register = 16'h0000, mem_rd_data, pop_data, stack_pointer_register;
	logic [15:0] mem_addr, mem_wr_data, frame_addr, s = 16'h0046, p, w;
	logic [31:0] q[$];
	logic [15:0] mm[int];
	int err_total = 0, total_checks = 0;
	always #5 clk = ~clk;
	sstk_top sstk_top_i (.*);
	sstk_ram sstk_ram_i (.clk(clk), .we(mem_wr_en), .re(mem_rd_en), .addr(mem_addr),
		.wd(mem_wr_data), .rd(mem_rd_data));
	function logic [15:0] rnd;
		s ^= s << 7;
		s ^= s >> 9;
		s ^= s << 8;
		return s;
	endfunction
	task chk(input logic [31:0] v, e);
		total_checks++;
		if (v !== e) begin
			err_total++;
			$display("unexpected at %0t: %h vs %h", $time, v, e);
		end
	endtask
	task test_done;
		if (err_total == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task nt(input logic [15:0] a, d);
		q.push_back({a, d});
		mm[a] = d;
	endtask
	task go(input sstk_op_type c);
		op_code = c;
		op_valid = 1'b1;
		@(posedge clk) #1 op_valid = 1'b0;
		chk(op_busy, c == SSTK_OP_SAVE_PC || c == SSTK_OP_POP);
		repeat (5) @(posedge clk);
		#1;
	endtask
	always @(posedge clk) begin
		if (mem_wr_en) chk({mem_addr, mem_wr_data}, q.pop_front());
		if (mem_rd_en) chk({mem_addr, 16'h0000}, q.pop_front());
		if (op_done && !mem_wr_en) chk({16'h0000, pop_data}, q.pop_front());
	end
	initial begin
		#20000;
		err_total++;
		test_done;
	end
	initial begin
		repeat (12) @(posedge clk);
		#1 reset_n = 1'b1;
		chk(stack_pointer_register, 16'h1000);
		w = (rnd() & 16'h0FFF) | 16'h2001;
		sw_wr_data = w;
		sw_wr_en = 1'b1;
		op_valid = 1'b1;
		op_code = SSTK_OP_PUSH;
		@(posedge clk) #1 sw_wr_en = 1'b0;
		op_valid = 1'b0;
		@(posedge clk) #1 p = w & 16'hFFFE;
		chk(stack_pointer_register, p);
		op_valid = 1'b1;
		repeat (3) begin
			push_data = rnd();
			nt(p, push_data);
			p += 16'h0002;
			@(posedge clk) #1;
		end
		op_valid = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		for (int e = 0; e < 2; e++) begin
			pc_value = 23'({rnd(), rnd()});
			cpu_status_register = rnd();
			op_is_exception = e[0];
			nt(p, pc_value[15:0]);
			nt(p + 16'h0002, {op_is_exception ? cpu_status_register[7:0] : 8'h00, 1'b0,
				pc_value[22:16]});
			p += 16'h0004;
			go(SSTK_OP_SAVE_PC);
		end
		chk(stack_pointer_register, p);
		repeat (2) begin
			p -= 16'h0002;
			q.push_back({p, 16'h0000});
			q.push_back({16'h0000, mm[p]});
			go(SSTK_OP_POP);
		end
		chk(stack_pointer_register, p);
		go(SSTK_OP_NONE);
		frame_pointer_active_flag = 1'b1;
		frame_pointer_register = rnd();
		repeat (2) @(posedge clk);
		#1 chk({frame_unpaged, frame_addr}, {1'b1, frame_pointer_register});
		chk(q.size(), 0);
		test_done;
	end
endmodule
